/* pls_pkg.sv */
// Notes on behaviour
// RULE1: In normal running the heartbeat lamp blinks once every second.
// RULE2: At startup the heartbeat lamp gives three short blinks in one second.
// RULE3: A soft restart holds the heartbeat lamp solidly on for two seconds.
// RULE4: A storage card scan gives three short heartbeat blinks in one second.
// RULE5: The test lamp lights on a test press and when its message is sent.
// RULE6: Each serial port has its own lamp, pulsed only by its own traffic.
// RULE7: Sensor lamp solid for five minutes after power-up if power is good.
// RULE8: Then the sensor lamp blinks once per analog sampling period.
// RULE9: Analog lamps blink every 2 s if low, every 1 s if high, else solid.
// RULE10: An analog lamp stays off unless its channel has range limits set.
// RULE11: Port two receive flashes heartbeat, its send flashes test lamp.
// RULE12: The test lamp stays lit while the test pushbutton is held.
// RULE13: All lamps go dark a set time after the last press; a press revives.
// RULE14: Burst and solid patterns override the normal blink until they end.
// RULE15: All timing comes from one free-running tick, cleared by reset.
`default_nettype none
package pls_pkg;

  // Clock and the millisecond tick that all lamp timing runs on.
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TICK_PERIOD_PS = 1000000000;
  localparam int TICK_CYCLES = TICK_PERIOD_PS / CLK_PERIOD_PS;

  // Widths of the short and the long millisecond counters.
  localparam int MS_W = 12;
  localparam int LONG_W = 20;

  // Heartbeat timing in milliseconds.
  localparam logic [MS_W-1:0] HB_PERIOD_MS = 12'h3E8;
  localparam logic [MS_W-1:0] HB_ON_MS = 12'h1F4;
  localparam logic [MS_W-1:0] BURST_WINDOW_MS = 12'h3E8;
  localparam logic [MS_W-1:0] BURST_SLOT_MS = 12'h12C;
  localparam logic [MS_W-1:0] BURST_ON_MS = 12'h064;
  localparam int BURST_COUNT = 3;
  localparam logic [MS_W-1:0] BURST_END_MS =
    MS_W'(BURST_COUNT) * BURST_SLOT_MS;
  localparam logic [MS_W-1:0] RESTART_SOLID_MS = 12'h7D0;

  // Analog range blink timing in milliseconds.
  localparam logic [MS_W-1:0] SLOW_BLINK_MS = 12'h7D0;
  localparam logic [MS_W-1:0] FAST_BLINK_MS = 12'h3E8;
  localparam logic [MS_W-1:0] RANGE_ON_MS = 12'h0FA;

  // Flash lengths in milliseconds.
  localparam logic [MS_W-1:0] ACTIVITY_MS = 12'h032;
  localparam logic [MS_W-1:0] TEST_FLASH_MS = 12'h064;
  localparam logic [MS_W-1:0] SAMPLE_FLASH_MS = 12'h064;

  // Long periods in milliseconds, five minutes each.
  localparam int SENSOR_SOLID_MS = 300000;
  localparam int LAMP_TIMEOUT_MS = 300000;

  // Reset value of the free-running counters.
  localparam logic [MS_W-1:0] COUNT_RESET = 12'h000;

  // Heartbeat pattern states.
  typedef enum logic [1:0] {
    HB_NORMAL,
    HB_BURST,
    HB_SOLID
  } pls_hb_state_t;

endpackage : pls_pkg
`default_nettype wire

/* pls_tick_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module pls_tick_gen #(
  parameter int unsigned CYCLES = pls_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Millisecond tick
  output logic msTick
);

  localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count_q;

  // Free-running divider; one pulse per wrap keeps every lamp in step.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      count_q <= '0;
      msTick <= 1'b0;
    end
    else
    begin
      msTick <= (count_q == LAST); // RULE15
      count_q <= (count_q == LAST) ? '0 : count_q + 1'b1; // RULE15
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_tickSingle;
    msTick |=> !msTick;
  endproperty
  a_tickSingle: assert property (p_tickSingle) // RULE15
    else $error("Tick lasted more than one cycle.");

  property p_tickAtWrap;
    (count_q == LAST) |=> msTick && (count_q == '0);
  endproperty
  a_tickAtWrap: assert property (p_tickAtWrap) // RULE15
    else $error("Tick did not follow the counter wrap.");

endmodule : pls_tick_gen
`default_nettype wire

/* pls_pulse_stretch.sv */
`timescale 1ns/1ps
`default_nettype none
module pls_pulse_stretch #(
  parameter logic [pls_pkg::MS_W-1:0] LEN_MS = pls_pkg::ACTIVITY_MS
) (
  // Clock, reset and tick
  input wire logic clk,
  input wire logic rst_n,
  input wire logic msTick,
  // Event in, stretched level out
  input wire logic trigger,
  output logic active
);

  logic [pls_pkg::MS_W-1:0] count_q;

  // A retrigger reloads, so steady traffic keeps the lamp lit.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      count_q <= pls_pkg::COUNT_RESET;
    else if (trigger)
      count_q <= LEN_MS;
    else if (msTick && count_q != '0)
      count_q <= count_q - 1'b1;
  end

  assign active = (count_q != '0);

endmodule : pls_pulse_stretch
`default_nettype wire

/* pls_led_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module pls_led_sequencer #(
  parameter int unsigned TICK_CYCLES = pls_pkg::TICK_CYCLES,
  parameter int unsigned SENSOR_SOLID_MS = pls_pkg::SENSOR_SOLID_MS,
  parameter int unsigned LAMP_TIMEOUT_MS = pls_pkg::LAMP_TIMEOUT_MS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Core status events
  input wire logic softRestart,
  input wire logic storageCardScan,
  input wire logic testPushbutton,
  input wire logic testMsgSent,
  input wire logic sensorPowerOk,
  input wire logic sampleStrobe,
  // Serial activity: bit 0 local, 1 field port one, 2 field port two
  input wire logic [2:0] portTx,
  input wire logic [2:0] portRx,
  // Analog range status per channel
  input wire logic [3:0] rangeConfigured,
  input wire logic [3:0] rangeLow,
  input wire logic [3:0] rangeHigh,
  // Lamps
  output logic heartbeatReceiveLamp,
  output logic testButtonTransmitLamp,
  output logic localActivityLamp,
  output logic fieldPortOneLamp,
  output logic fieldPortTwoLamp,
  output logic sensorPowerLamp,
  output logic analogChannelZeroLamp,
  output logic analogChannelOneLamp,
  output logic analogChannelTwoLamp,
  output logic analogChannelThreeLamp
);

  localparam int MW = pls_pkg::MS_W;
  localparam int LW = pls_pkg::LONG_W;

  logic msTick;
  logic [MW-1:0] msCount_q;
  logic testPrev_q;
  logic pressEdge;
  logic [LW-1:0] idleMs_q;
  logic lampsOn;
  logic [LW-1:0] sensorMs_q;
  logic sensorSolid;
  pls_pkg::pls_hb_state_t hbState_q;
  logic [MW-1:0] hbTimer_q;
  logic scanPending_q;
  logic hbPattern;
  logic [2:0] portFlash;
  logic rxTwoFlash;
  logic txTwoFlash;
  logic msgFlash;
  logic sampleFlash;
  logic [3:0] analogLamp_q;
  logic slowOn;
  logic fastOn;

  // True while a millisecond count sits in the lit part of its period.
  function automatic logic phaseOn(input logic [MW-1:0] ms,
                                   input logic [MW-1:0] period,
                                   input logic [MW-1:0] onMs);
    phaseOn = (ms % period) < onMs;
  endfunction : phaseOn

  // One tick source for every period in the block.
  pls_tick_gen #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .msTick(msTick)
  );

  // Shared blink phase; two seconds covers every blink period in use.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      msCount_q <= pls_pkg::COUNT_RESET;
    else if (msTick)
      msCount_q <= (msCount_q == pls_pkg::SLOW_BLINK_MS - 12'h001) ?
                   pls_pkg::COUNT_RESET : msCount_q + 1'b1; // RULE15
  end

  // A new press is an edge, so a held button does not keep re-arming.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      testPrev_q <= 1'b0;
    else
      testPrev_q <= testPushbutton;
  end
  assign pressEdge = testPushbutton & ~testPrev_q;

  // Lamp timeout; the counter stops at the limit instead of wrapping.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      idleMs_q <= '0;
    else if (pressEdge)
      idleMs_q <= '0; // RULE13
    else if (msTick && lampsOn)
      idleMs_q <= idleMs_q + 1'b1; // RULE13
  end
  assign lampsOn = idleMs_q < LW'(LAMP_TIMEOUT_MS); // RULE13

  // Sensor solid period after power-up, also saturating.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sensorMs_q <= '0;
    else if (msTick && sensorSolid)
      sensorMs_q <= sensorMs_q + 1'b1; // RULE7
  end
  assign sensorSolid = sensorMs_q < LW'(SENSOR_SOLID_MS);

  // Heartbeat pattern sequencer; reset enters the startup burst.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      hbState_q <= pls_pkg::HB_BURST; // RULE2
      hbTimer_q <= pls_pkg::COUNT_RESET;
    end
    else if (softRestart)
    begin
      hbState_q <= pls_pkg::HB_SOLID; // RULE3
      hbTimer_q <= pls_pkg::COUNT_RESET;
    end
    else
    begin
      case (hbState_q)
        pls_pkg::HB_NORMAL:
          if (storageCardScan || scanPending_q)
          begin
            hbState_q <= pls_pkg::HB_BURST; // RULE4
            hbTimer_q <= pls_pkg::COUNT_RESET;
          end
        pls_pkg::HB_BURST:
          if (msTick)
          begin
            if (hbTimer_q == pls_pkg::BURST_WINDOW_MS - 12'h001)
            begin
              hbState_q <= pls_pkg::HB_NORMAL; // RULE14
              hbTimer_q <= pls_pkg::COUNT_RESET;
            end
            else
              hbTimer_q <= hbTimer_q + 1'b1;
          end
        pls_pkg::HB_SOLID:
          if (msTick)
          begin
            if (hbTimer_q == pls_pkg::RESTART_SOLID_MS - 12'h001)
            begin
              hbState_q <= pls_pkg::HB_NORMAL; // RULE14
              hbTimer_q <= pls_pkg::COUNT_RESET;
            end
            else
              hbTimer_q <= hbTimer_q + 1'b1;
          end
        default:
        begin
          hbState_q <= pls_pkg::HB_NORMAL;
          hbTimer_q <= pls_pkg::COUNT_RESET;
        end
      endcase
    end
  end

  // A scan asked for while another pattern runs waits its turn; the
  // request wins over the clear in the same cycle.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      scanPending_q <= 1'b0;
    else if (storageCardScan &&
             (hbState_q != pls_pkg::HB_NORMAL || softRestart))
      scanPending_q <= 1'b1; // RULE14
    else if (hbState_q == pls_pkg::HB_NORMAL && !softRestart)
      scanPending_q <= 1'b0;
  end

  // Heartbeat pattern for the current state.
  always_comb
  begin
    case (hbState_q)
      pls_pkg::HB_BURST:
        hbPattern = (hbTimer_q < pls_pkg::BURST_END_MS) &&
                    phaseOn(hbTimer_q, pls_pkg::BURST_SLOT_MS,
                            pls_pkg::BURST_ON_MS); // RULE2 RULE4
      pls_pkg::HB_SOLID:
        hbPattern = 1'b1; // RULE3
      default:
        hbPattern = phaseOn(msCount_q, pls_pkg::HB_PERIOD_MS,
                            pls_pkg::HB_ON_MS); // RULE1
    endcase
  end

  // Per-port activity flashes, each fed only by its own port.
  for (genvar p = 0; p < 3; p++)
  begin : g_port
    pls_pulse_stretch #(
      .LEN_MS(pls_pkg::ACTIVITY_MS)
    ) u_act (
      .clk(clk),
      .rst_n(rst_n),
      .msTick(msTick),
      .trigger(portTx[p] | portRx[p]), // RULE6
      .active(portFlash[p])
    );
  end

  // Field port two receive shares the heartbeat lamp.
  pls_pulse_stretch #(
    .LEN_MS(pls_pkg::ACTIVITY_MS)
  ) u_rxTwo (
    .clk(clk),
    .rst_n(rst_n),
    .msTick(msTick),
    .trigger(portRx[2]), // RULE11
    .active(rxTwoFlash)
  );

  // Field port two transmit shares the test lamp.
  pls_pulse_stretch #(
    .LEN_MS(pls_pkg::TEST_FLASH_MS)
  ) u_txTwo (
    .clk(clk),
    .rst_n(rst_n),
    .msTick(msTick),
    .trigger(portTx[2]), // RULE11
    .active(txTwoFlash)
  );

  // Sending the test message keeps the test lamp lit briefly.
  pls_pulse_stretch #(
    .LEN_MS(pls_pkg::TEST_FLASH_MS)
  ) u_msg (
    .clk(clk),
    .rst_n(rst_n),
    .msTick(msTick),
    .trigger(testMsgSent), // RULE5
    .active(msgFlash)
  );

  // One flash per analog sample once the solid period is over.
  pls_pulse_stretch #(
    .LEN_MS(pls_pkg::SAMPLE_FLASH_MS)
  ) u_sample (
    .clk(clk),
    .rst_n(rst_n),
    .msTick(msTick),
    .trigger(sampleStrobe), // RULE8
    .active(sampleFlash)
  );

  // Range blink phases; low is the slow rate and wins if both are set.
  assign slowOn = phaseOn(msCount_q, pls_pkg::SLOW_BLINK_MS,
                          pls_pkg::RANGE_ON_MS);
  assign fastOn = phaseOn(msCount_q, pls_pkg::FAST_BLINK_MS,
                          pls_pkg::RANGE_ON_MS);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      analogLamp_q <= '0;
    else
      for (int i = 0; i < 4; i++)
        analogLamp_q[i] <= lampsOn && rangeConfigured[i] && // RULE10
                           (rangeLow[i] ? slowOn :
                            rangeHigh[i] ? fastOn : 1'b1); // RULE9
  end
  assign analogChannelZeroLamp = analogLamp_q[0];
  assign analogChannelOneLamp = analogLamp_q[1];
  assign analogChannelTwoLamp = analogLamp_q[2];
  assign analogChannelThreeLamp = analogLamp_q[3];

  // Lamp drivers; a timed-out panel goes fully dark to save battery.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      heartbeatReceiveLamp <= 1'b0;
      testButtonTransmitLamp <= 1'b0;
      localActivityLamp <= 1'b0;
      fieldPortOneLamp <= 1'b0;
      fieldPortTwoLamp <= 1'b0;
      sensorPowerLamp <= 1'b0;
    end
    else
    begin
      heartbeatReceiveLamp <= lampsOn && (hbPattern || rxTwoFlash); // RULE11
      testButtonTransmitLamp <= lampsOn &&
        (testPushbutton || msgFlash || txTwoFlash); // RULE12 RULE5
      localActivityLamp <= lampsOn && portFlash[0]; // RULE6
      fieldPortOneLamp <= lampsOn && portFlash[1]; // RULE6
      fieldPortTwoLamp <= lampsOn && portFlash[2]; // RULE6
      sensorPowerLamp <= lampsOn && sensorPowerOk &&
        (sensorSolid || sampleFlash); // RULE7 RULE8
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_litTwo(logic ev);
    ev && lampsOn ##1 lampsOn;
  endsequence

  property p_normalBlink;
    hbState_q == pls_pkg::HB_NORMAL && lampsOn && !rxTwoFlash |=>
      heartbeatReceiveLamp == $past(msCount_q % 12'h3E8 < 12'h1F4);
  endproperty
  a_normalBlink: assert property (p_normalBlink) // RULE1
    else $error("Heartbeat does not follow the one second blink.");

  property p_burstEnds;
    hbState_q == pls_pkg::HB_BURST && hbTimer_q >= 12'h384 && lampsOn &&
      !rxTwoFlash |=> !heartbeatReceiveLamp;
  endproperty
  a_burstEnds: assert property (p_burstEnds) // RULE2
    else $error("Heartbeat lit after the third burst blink.");

  property p_restartSolid;
    softRestart |=> hbState_q == pls_pkg::HB_SOLID && hbTimer_q == '0
      ##1 (!$past(lampsOn) || heartbeatReceiveLamp);
  endproperty
  a_restartSolid: assert property (p_restartSolid) // RULE3
    else $error("Soft restart did not light the heartbeat solidly.");

  property p_scanBurst;
    storageCardScan && !softRestart && hbState_q == pls_pkg::HB_NORMAL |=>
      hbState_q == pls_pkg::HB_BURST && hbTimer_q == '0;
  endproperty
  a_scanBurst: assert property (p_scanBurst) // RULE4
    else $error("Card scan did not start a burst.");

  property p_msgLamp;
    s_litTwo(testMsgSent) |=> testButtonTransmitLamp;
  endproperty
  a_msgLamp: assert property (p_msgLamp) // RULE5
    else $error("Sent test message did not light the test lamp.");

  property p_portOwn;
    s_litTwo(portRx[1]) |=> fieldPortOneLamp ##0
      (localActivityLamp == $past(portFlash[0]));
  endproperty
  a_portOwn: assert property (p_portOwn) // RULE6
    else $error("Port activity lamp wrong or shared.");

  property p_sensorSolid;
    sensorPowerOk && sensorSolid && lampsOn |=> sensorPowerLamp;
  endproperty
  a_sensorSolid: assert property (p_sensorSolid) // RULE7
    else $error("Sensor lamp dark during the solid period.");

  property p_sensorIdle;
    !sensorSolid && !sampleFlash |=> !sensorPowerLamp;
  endproperty
  a_sensorIdle: assert property (p_sensorIdle) // RULE8
    else $error("Sensor lamp lit without a sample.");

  property p_rangeNormal;
    lampsOn && rangeConfigured[1] && !rangeLow[1] && !rangeHigh[1] |=>
      analogChannelOneLamp;
  endproperty
  a_rangeNormal: assert property (p_rangeNormal) // RULE9
    else $error("Normal range channel not solid.");

  property p_rangeUnset;
    !rangeConfigured[0] |=> !analogChannelZeroLamp;
  endproperty
  a_rangeUnset: assert property (p_rangeUnset) // RULE10
    else $error("Unconfigured channel lamp lit.");

  property p_rxTwoHeartbeat;
    s_litTwo(portRx[2]) |=> heartbeatReceiveLamp;
  endproperty
  a_rxTwoHeartbeat: assert property (p_rxTwoHeartbeat) // RULE11
    else $error("Field port two receive did not flash heartbeat.");

  property p_testHeld;
    testPushbutton && lampsOn |=> testButtonTransmitLamp;
  endproperty
  a_testHeld: assert property (p_testHeld) // RULE12
    else $error("Held test button left its lamp dark.");

  property p_darkPanel;
    !lampsOn && !pressEdge |=> !lampsOn && !heartbeatReceiveLamp &&
      !testButtonTransmitLamp && !sensorPowerLamp && analogLamp_q == '0;
  endproperty
  a_darkPanel: assert property (p_darkPanel) // RULE13
    else $error("Lamp lit after the panel timed out.");

  property p_pressRevives;
    pressEdge |=> idleMs_q == '0 && lampsOn;
  endproperty
  a_pressRevives: assert property (p_pressRevives) // RULE13
    else $error("Test press did not revive the panel.");

  property p_patternHolds;
    hbState_q == pls_pkg::HB_SOLID && !msTick |=>
      hbState_q != pls_pkg::HB_NORMAL;
  endproperty
  a_patternHolds: assert property (p_patternHolds) // RULE14
    else $error("Restart pattern left early.");

endmodule : pls_led_sequencer
`default_nettype wire

/* pls_led_panel.sv */
`timescale 1ns/1ps
`default_nettype none
// Bank of discrete front-panel lamps seen as the far side of the sequencer.
// It keeps no state of its own beyond what a window of counting needs.
module pls_led_panel (
  // Clock and window clear
  input wire logic clk,
  input wire logic clear,
  // Lamp drives, high means lit
  input wire logic [9:0] lamps,
  // Lit cycles and turn-on events per lamp since the last clear
  output logic [9:0][31:0] litCycles,
  output logic [9:0][31:0] turnOns
);
  logic [9:0] lampsPrev_q;

  // The previous level is never cleared, so a lamp already lit when a window
  // opens is not counted as a fresh turn-on.
  always_ff @(posedge clk)
  begin
    lampsPrev_q <= lamps;
  end

  // Counting window; a clear drops both tallies for every lamp.
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 10; i++)
    begin
      if (clear)
      begin
        litCycles[i] <= 32'h0000_0000;
        turnOns[i] <= 32'h0000_0000;
      end
      else
      begin
        litCycles[i] <= litCycles[i] + {31'h0000_0000, lamps[i]};
        turnOns[i] <= turnOns[i] +
          {31'h0000_0000, lamps[i] & ~lampsPrev_q[i]};
      end
    end
  end
endmodule : pls_led_panel
`default_nettype wire

/* pls_led_sequencer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module pls_led_sequencer_bench;
  // Short tick and timeout keep the whole run near twenty thousand cycles.
  localparam int TK = 2;
  localparam int TOUT = 8000;
  localparam int TOL = 8;
  logic clk;
  logic rst_n;
  logic softRestart, storageCardScan, testPushbutton, testMsgSent;
  logic sensorPowerOk, sampleStrobe, panelClr;
  logic [2:0] portTx, portRx;
  logic [3:0] rangeConfigured, rangeLow, rangeHigh;
  wire logic [9:0] lamps;
  wire logic [9:0][31:0] lit;
  wire logic [9:0][31:0] ons;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  int pressCyc = 0;
  int winCyc = 0;
  int p;
  int w;

  pls_led_sequencer #(
    .TICK_CYCLES(TK),
    .SENSOR_SOLID_MS(50),
    .LAMP_TIMEOUT_MS(TOUT)
  ) i_pls_led_sequencer (
    .clk(clk),
    .rst_n(rst_n),
    .softRestart(softRestart),
    .storageCardScan(storageCardScan),
    .testPushbutton(testPushbutton),
    .testMsgSent(testMsgSent),
    .sensorPowerOk(sensorPowerOk),
    .sampleStrobe(sampleStrobe),
    .portTx(portTx),
    .portRx(portRx),
    .rangeConfigured(rangeConfigured),
    .rangeLow(rangeLow),
    .rangeHigh(rangeHigh),
    .heartbeatReceiveLamp(lamps[0]),
    .testButtonTransmitLamp(lamps[1]),
    .localActivityLamp(lamps[2]),
    .fieldPortOneLamp(lamps[3]),
    .fieldPortTwoLamp(lamps[4]),
    .sensorPowerLamp(lamps[5]),
    .analogChannelZeroLamp(lamps[6]),
    .analogChannelOneLamp(lamps[7]),
    .analogChannelTwoLamp(lamps[8]),
    .analogChannelThreeLamp(lamps[9])
  );

  pls_led_panel i_pls_led_panel (
    .clk(clk),
    .clear(panelClr),
    .lamps(lamps),
    .litCycles(lit),
    .turnOns(ons)
  );

  // Free-running clock at 200 MHz.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Cycle count of the reference model; time is reckoned in ms from it.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
  end

  // Watchdog sized well past the planned sequence length.
  initial
  begin
    repeat (30000) @(posedge clk);
    fail_count++;
    results();
  end

  task automatic results;
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  // One compare against an inclusive range; an unknown never passes.
  task automatic chk(input logic [31:0] got, input int lo, input int hi);
    check_count++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk

  // Lit time of one lamp over the open window, in ms with a tolerance.
  task automatic chkLit(input int idx, input int ms, input int tol);
    chk(lit[idx], (ms > tol) ? (ms - tol) * TK : 0, (ms + tol) * TK);
  endtask : chkLit

  // Reference lit time of a slow-blink lamp between two cycle counts; the
  // blink phase is the ms count since release, wrapped at the slow period.
  function automatic int slowLitMs(input int c0, input int c1);
    int n;
    n = 0;
    for (int m = (c0 - 3) / TK; m < (c1 - 3) / TK; m++)
      if (m % int'(pls_pkg::SLOW_BLINK_MS) < int'(pls_pkg::RANGE_ON_MS))
        n++;
    return n;
  endfunction : slowLitMs

  task automatic waitMs(input int n);
    repeat (n * TK) @(posedge clk);
    #1;
  endtask : waitMs

  task automatic drive(input int sel, input logic v);
    case (sel)
      0: softRestart <= v;
      1: storageCardScan <= v;
      2: testMsgSent <= v;
      3: sampleStrobe <= v;
      4, 5, 6: portTx[sel - 4] <= v;
      7, 8, 9: portRx[sel - 7] <= v;
      default: testPushbutton <= v;
    endcase
  endtask : drive

  // Event inputs rise and fall on clock edges, held for width cycles.
  task automatic pulseIn(input int sel, input int width);
    @(posedge clk);
    drive(sel, 1'b1);
    repeat (width) @(posedge clk);
    drive(sel, 1'b0);
    #1;
  endtask : pulseIn

  task automatic openWin;
    @(posedge clk);
    panelClr <= 1'b1;
    @(posedge clk);
    panelClr <= 1'b0;
    #1;
    winCyc = cyc;
  endtask : openWin

  // Main sequence; channel zero is unconfigured with both range flags set.
  initial
  begin
    rst_n = 1'b0;
    panelClr = 1'b1;
    {softRestart, storageCardScan, testPushbutton, testMsgSent} = 4'h0;
    sensorPowerOk = 1'b1;
    sampleStrobe = 1'b0;
    portTx = 3'h0;
    portRx = 3'h0;
    rangeConfigured = 4'hE;
    rangeLow = 4'h5;
    rangeHigh = 4'h9;
    void'($urandom(32'h6AE6));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    panelClr <= 1'b0;
    #1;
    // Startup burst with a port-two receive flash placed in its first gap.
    waitMs(20);
    chk({31'h0, lamps[5]}, 1, 1);
    waitMs(80);
    chk({31'h0, lamps[5]}, 0, 0);
    waitMs(50);
    pulseIn(9, 2);
    waitMs(24);
    chk({31'h0, lamps[0]}, 1, 1);
    waitMs(75);
    chk({31'h0, lamps[0]}, 0, 0);
    waitMs(150);
    pulseIn(3, 1);
    waitMs(300);
    pulseIn(3, 1);
    waitMs(240);
    chk(ons[0], 4, 4);
    chkLit(0, 350, TOL);
    chk(ons[5], 3, 3);
    chkLit(5, 250, TOL);
    // Each port direction lights only its own port lamp; port-two sends hit test.
    for (int i = 0; i < 6; i++)
    begin
      p = i % 3;
      repeat ($urandom_range(15, 0)) @(posedge clk);
      w = $urandom_range(3, 1);
      pulseIn((i < 3) ? 7 + p : 4 + p, w);
      waitMs(25);
      chk({29'h0, lamps[4:2]}, 1 << p, 1 << p);
      chk({31'h0, lamps[1]}, (i == 5), (i == 5));
      waitMs(55);
      chk({29'h0, lamps[4:2]}, 0, 0);
    end
    pulseIn(2, 1);
    waitMs(50);
    chk({31'h0, lamps[1]}, 1, 1);
    waitMs(80);
    chk({31'h0, lamps[1]}, 0, 0);
    @(posedge clk);
    testPushbutton <= 1'b1;
    pressCyc = cyc;
    waitMs(300);
    chk({31'h0, lamps[1]}, 1, 1);
    @(posedge clk);
    testPushbutton <= 1'b0;
    waitMs(5);
    chk({31'h0, lamps[1]}, 0, 0);
    // Two seconds of normal heartbeat and range lamps; sensor power lost.
    @(posedge clk);
    sensorPowerOk <= 1'b0;
    openWin();
    waitMs(1000);
    pulseIn(3, 1);
    waitMs(1000);
    chkLit(0, 1000, TOL);
    chkLit(5, 0, 0);
    chkLit(6, 0, 0);
    chkLit(7, 2000, TOL);
    chkLit(8, 250, TOL);
    chkLit(9, 500, TOL);
    // Restart with a scan queued behind it; low wins over high on channel 0.
    @(posedge clk);
    rangeConfigured <= 4'hF;
    pulseIn(0, 1);
    waitMs(10);
    openWin();
    waitMs(490);
    pulseIn(1, 1);
    waitMs(1480);
    chkLit(0, 1971, TOL);
    chkLit(6, slowLitMs(winCyc, cyc), 25);
    waitMs(30);
    openWin();
    waitMs(880);
    chkLit(0, 290, 12);
    chk(ons[0], 2, 3);
    // A scan asked for in normal running starts its burst at once.
    waitMs(120);
    openWin();
    pulseIn(1, 1);
    waitMs(998);
    chkLit(0, 300, TOL);
    chk(ons[0], 2, 3);
    // Panel goes dark after the idle time, then a brief press revives it.
    while (cyc < pressCyc + (TOUT + 20) * TK) @(posedge clk);
    #1;
    chk({22'h0, lamps}, 0, 0);
    pulseIn(10, 40);
    waitMs(5);
    chk({31'h0, lamps[7]}, 1, 1);
    results();
  end
endmodule : pls_led_sequencer_bench
`default_nettype wire
